/* File: hdl/lbi_bus_ctrl.sv */
// Local bus control: bus cycle sequencer, pin drive, ready and hold handover.
// Assumes core requests are synchronous to i_core_clk and pins are resolved outside.
//
// Behaviour
// - Address valid on muxed bus at latch fall.
// - Async ready active high, synchronised internally.
// - Async ready low: sync ready decides.
// - Byte enable and ad0 encode cycle type.
// - Byte enable floats in hold, held T1-T3.
// - Refresh identified by ad0, not linear A0.
// - Strap high: disable bit suppresses region addresses.
// - Strap low: always drive address and data.
// - Strap sampled one clock after reset.
// - Data enable on transfers, off at direction change.
// - Direction high transmit, low receive, floats.
// - Finish current cycle, then acknowledge hold.
// - Acknowledge floats outputs, then selects go high.
// - Hold released, acknowledge drops in response.
// - Device may reclaim bus by dropping acknowledge.
// - Hold ranks below DMA refresh, above others.
// - Hold latency grows with locked transfers.
// - Address in T1, data in T2 through T4.
// - Upper byte floats when high write inactive.
`timescale 1ns/1ps
module lbi_bus_ctrl #(
  parameter int ADDR_W = lbi_pkg::ADDR_W,
  parameter int DATA_W = lbi_pkg::DATA_W
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_ce,
  input  wire logic              i_req_valid,
  input  wire logic              i_req_write,
  input  wire logic              i_req_word,
  input  wire logic              i_req_io,
  input  wire logic              i_req_inta,
  input  wire logic              i_req_refresh,
  input  wire logic              i_req_lock,
  input  wire logic [1:0]        i_req_region,
  input  wire logic [ADDR_W-1:0] i_req_addr,
  input  wire logic [DATA_W-1:0] i_req_wdata,
  output logic                   o_req_ready,
  output logic [DATA_W-1:0]      o_rd_data,
  output logic                   o_rd_valid,
  input  wire logic              i_lower_addr_disable_bit,
  input  wire logic              i_upper_addr_disable_bit,
  input  wire logic              i_async_ready,
  input  wire logic              i_sync_ready,
  input  wire logic              i_hold,
  output logic                   o_hlda,
  output logic                   o_cs_force_high,
  output logic                   o_ale,
  input  wire logic              i_bhe_aden_n,
  output logic                   o_bhe_n,
  output logic                   o_bhe_oe_n,
  input  wire logic [DATA_W-1:0] i_muxed_addr_data,
  output logic [DATA_W-1:0]      o_muxed_addr_data,
  output logic                   o_mad_hi_oe_n,
  output logic                   o_mad_lo_oe_n,
  output logic [ADDR_W-1:0]      o_linear_address_out,
  output logic                   o_linear_oe_n,
  output logic [2:0]             o_bus_status_n,
  output logic                   o_rd_n,
  output logic                   o_wr_n,
  output logic                   o_whb_n,
  output logic                   o_wlb_n,
  output logic                   o_strobe_oe_n,
  output logic                   o_data_enable_n,
  output logic                   o_den_oe_n,
  output logic                   o_data_direction,
  output logic                   o_dir_oe_n
);

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic hi_lane(input logic word, input logic a0);
    hi_lane = word || a0;
  endfunction

  function automatic logic lo_lane(input logic word, input logic a0);
    lo_lane = word || !a0;
  endfunction

  function automatic logic in_data_phase(input lbi_pkg::lbi_state_t st);
    in_data_phase = (st == lbi_pkg::ST_T2) || (st == lbi_pkg::ST_T3) ||
                    (st == lbi_pkg::ST_TW) || (st == lbi_pkg::ST_T4);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  logic [1:0] sync_out;
  logic       hold_s;
  logic       async_s;
  logic       strap_low;
  logic       rdy;

  lbi_sync #(
    .WIDTH  (2),
    .STAGES (lbi_pkg::SYNC_STAGES)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_ce       (i_ce),
    .i_async    ({i_hold, i_async_ready}),
    .o_sync     (sync_out)
  );

  assign hold_s  = sync_out[1];
  assign async_s = sync_out[0];

  lbi_strap u_strap (
    .i_core_clk  (i_core_clk),
    .i_nrst      (i_nrst),
    .i_ce        (i_ce),
    .i_strap     (i_bhe_aden_n),
    .o_strap_low (strap_low)
  );

  // Held-high async ready forces ready; held low leaves sync ready alone.
  assign rdy = async_s || i_sync_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer and cycle attributes.

  lbi_pkg::lbi_state_t state;
  lbi_pkg::lbi_state_t next_state;
  logic [ADDR_W-1:0]   cyc_addr;
  logic [ADDR_W-1:0]   next_cyc_addr;
  logic [DATA_W-1:0]   cyc_wdata;
  logic [DATA_W-1:0]   next_cyc_wdata;
  logic                cyc_write;
  logic                next_cyc_write;
  logic                cyc_word;
  logic                next_cyc_word;
  logic                cyc_io;
  logic                next_cyc_io;
  logic                cyc_inta;
  logic                next_cyc_inta;
  logic                cyc_refresh;
  logic                next_cyc_refresh;
  logic                cyc_suppress;
  logic                next_cyc_suppress;
  logic                locked;
  logic                next_locked;
  logic [DATA_W-1:0]   next_rd_data;
  logic                next_rd_valid;
  logic                start;

  always_comb begin
    next_state        = state;
    next_cyc_addr     = cyc_addr;
    next_cyc_wdata    = cyc_wdata;
    next_cyc_write    = cyc_write;
    next_cyc_word     = cyc_word;
    next_cyc_io       = cyc_io;
    next_cyc_inta     = cyc_inta;
    next_cyc_refresh  = cyc_refresh;
    next_cyc_suppress = cyc_suppress;
    next_locked       = locked;
    next_rd_data      = o_rd_data;
    next_rd_valid     = 1'b0;
    start             = 1'b0;
    case (state)
      lbi_pkg::ST_IDLE, lbi_pkg::ST_T4: begin
        // Hold is only weighed at a cycle boundary, never mid-cycle.
        if (i_req_valid && i_req_refresh) begin
          start = 1'b1;
        end else if (hold_s && !locked) begin
          next_state = lbi_pkg::ST_HOLD_ENTER;
        end else if (i_req_valid) begin
          start = 1'b1;
        end else begin
          next_state  = lbi_pkg::ST_IDLE;
          next_locked = 1'b0;
        end
      end
      lbi_pkg::ST_T1: next_state = lbi_pkg::ST_T2;
      lbi_pkg::ST_T2: next_state = lbi_pkg::ST_T3;
      lbi_pkg::ST_T3, lbi_pkg::ST_TW: begin
        if (rdy) begin
          next_state    = lbi_pkg::ST_T4;
          next_rd_data  = i_muxed_addr_data;
          next_rd_valid = !cyc_write && !cyc_refresh;
        end else begin
          next_state = lbi_pkg::ST_TW;
        end
      end
      lbi_pkg::ST_HOLD_ENTER, lbi_pkg::ST_HOLD: begin
        // A pending refresh takes the bus back while hold is still high.
        if (!hold_s || (i_req_valid && i_req_refresh)) begin
          next_state = lbi_pkg::ST_IDLE;
        end else begin
          next_state = lbi_pkg::ST_HOLD;
        end
      end
      default: next_state = lbi_pkg::ST_IDLE;
    endcase
    if (start) begin
      next_state       = lbi_pkg::ST_T1;
      next_cyc_addr    = i_req_addr;
      next_cyc_wdata   = i_req_wdata;
      next_cyc_write   = i_req_write && !i_req_refresh;
      next_cyc_word    = i_req_word;
      next_cyc_io      = i_req_io;
      next_cyc_inta    = i_req_inta;
      next_cyc_refresh = i_req_refresh;
      // A locked sequence keeps hold out until it ends.
      next_locked      = i_req_lock;
      // Strap low overrides the disable bit entirely.
      next_cyc_suppress = !strap_low &&
        (((i_req_region == lbi_pkg::REGION_LOWER) && i_lower_addr_disable_bit) ||
         ((i_req_region == lbi_pkg::REGION_UPPER) && i_upper_addr_disable_bit));
    end
  end

  assign o_req_ready = i_ce && start;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      state        <= lbi_pkg::ST_IDLE;
      cyc_addr     <= '0;
      cyc_wdata    <= '0;
      cyc_write    <= 1'b0;
      cyc_word     <= 1'b0;
      cyc_io       <= 1'b0;
      cyc_inta     <= 1'b0;
      cyc_refresh  <= 1'b0;
      cyc_suppress <= 1'b0;
      locked       <= 1'b0;
      o_rd_data    <= '0;
      o_rd_valid   <= 1'b0;
    end else if (i_ce) begin
      state        <= next_state;
      cyc_addr     <= next_cyc_addr;
      cyc_wdata    <= next_cyc_wdata;
      cyc_write    <= next_cyc_write;
      cyc_word     <= next_cyc_word;
      cyc_io       <= next_cyc_io;
      cyc_inta     <= next_cyc_inta;
      cyc_refresh  <= next_cyc_refresh;
      cyc_suppress <= next_cyc_suppress;
      locked       <= next_locked;
      o_rd_data    <= next_rd_data;
      o_rd_valid   <= next_rd_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive, registered from the next state so pins and state move together.

  logic              nx_float;
  logic              nx_active;
  logic              nx_hi;
  logic              nx_lo;
  logic              nx_hlda;
  logic              nx_cs_high;
  logic              nx_ale;
  logic              nx_bhe_n;
  logic [DATA_W-1:0] nx_mad;
  logic              nx_mad_hi_oe_n;
  logic              nx_mad_lo_oe_n;
  logic [2:0]        nx_status_n;
  logic              nx_rd_n;
  logic              nx_wr_n;
  logic              nx_whb_n;
  logic              nx_wlb_n;
  logic              nx_den_n;
  logic              nx_dir;
  logic              nx_bhe_oe_n;
  logic              bhe_drive_ok;

  always_comb begin
    nx_float   = (next_state == lbi_pkg::ST_HOLD_ENTER) || (next_state == lbi_pkg::ST_HOLD);
    nx_active  = (next_state == lbi_pkg::ST_T1) || (next_state == lbi_pkg::ST_T2) ||
                 (next_state == lbi_pkg::ST_T3) || (next_state == lbi_pkg::ST_TW);
    nx_hi      = hi_lane(next_cyc_word, next_cyc_addr[0]) && !next_cyc_refresh;
    nx_lo      = lo_lane(next_cyc_word, next_cyc_addr[0]) && !next_cyc_refresh;
    nx_hlda    = nx_float;
    // Selects go high only once the other outputs are already floated.
    nx_cs_high = (next_state == lbi_pkg::ST_HOLD);
    nx_ale     = (next_state == lbi_pkg::ST_T1);
    // Refresh shows 1,1; otherwise the lane decode drives bhe_n.
    nx_bhe_n   = !(nx_active && nx_hi);
    // The strap shares this pin, so it stays floated until the strap is read.
    nx_bhe_oe_n = nx_float || !bhe_drive_ok;
    nx_mad         = next_cyc_wdata;
    nx_mad_hi_oe_n = 1'b1;
    nx_mad_lo_oe_n = 1'b1;
    nx_whb_n       = 1'b1;
    nx_wlb_n       = 1'b1;
    nx_wr_n        = 1'b1;
    nx_rd_n        = 1'b1;
    nx_den_n       = 1'b1;
    nx_dir         = o_data_direction;
    nx_status_n    = lbi_pkg::STAT_PASSIVE;
    if (next_state == lbi_pkg::ST_T1) begin
      // ad0 carries the refresh mark; the linear bus keeps the true A0.
      nx_mad         = {next_cyc_addr[DATA_W-1:1], next_cyc_addr[0] || next_cyc_refresh};
      nx_mad_hi_oe_n = next_cyc_suppress;
      nx_mad_lo_oe_n = next_cyc_suppress;
      // Direction settles in T1 while data enable is still off.
      nx_dir         = next_cyc_write;
    end
    if (in_data_phase(next_state)) begin
      nx_whb_n       = !(next_cyc_write && nx_hi);
      nx_wlb_n       = !(next_cyc_write && nx_lo);
      nx_wr_n        = !next_cyc_write;
      nx_rd_n        = next_cyc_write || next_cyc_refresh;
      // Each data byte is driven only while its write strobe is active.
      nx_mad_hi_oe_n = nx_whb_n;
      nx_mad_lo_oe_n = nx_wlb_n;
      nx_den_n       = next_cyc_refresh;
    end
    if (nx_active) begin
      if (next_cyc_inta) begin
        nx_status_n = lbi_pkg::STAT_INTA;
      end else if (next_cyc_io) begin
        nx_status_n = next_cyc_write ? lbi_pkg::STAT_IO_WR : lbi_pkg::STAT_IO_RD;
      end else begin
        nx_status_n = next_cyc_write ? lbi_pkg::STAT_MEM_WR : lbi_pkg::STAT_MEM_RD;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      // Everything that floats in hold also floats in reset.
      o_hlda               <= 1'b0;
      o_cs_force_high      <= 1'b0;
      o_ale                <= 1'b0;
      o_bhe_n              <= 1'b1;
      o_bhe_oe_n           <= 1'b1;
      bhe_drive_ok         <= 1'b0;
      o_muxed_addr_data    <= '0;
      o_mad_hi_oe_n        <= 1'b1;
      o_mad_lo_oe_n        <= 1'b1;
      o_linear_address_out <= '0;
      o_linear_oe_n        <= 1'b1;
      o_bus_status_n       <= lbi_pkg::STAT_PASSIVE;
      o_rd_n               <= 1'b1;
      o_wr_n               <= 1'b1;
      o_whb_n              <= 1'b1;
      o_wlb_n              <= 1'b1;
      o_strobe_oe_n        <= 1'b1;
      o_data_enable_n      <= 1'b1;
      o_den_oe_n           <= 1'b1;
      o_data_direction     <= 1'b0;
      o_dir_oe_n           <= 1'b1;
    end else if (i_ce) begin
      o_hlda               <= nx_hlda;
      o_cs_force_high      <= nx_cs_high;
      o_ale                <= nx_ale;
      o_bhe_n              <= nx_bhe_n;
      o_bhe_oe_n           <= nx_bhe_oe_n;
      bhe_drive_ok         <= 1'b1;
      o_muxed_addr_data    <= nx_mad;
      o_mad_hi_oe_n        <= nx_mad_hi_oe_n || nx_float;
      o_mad_lo_oe_n        <= nx_mad_lo_oe_n || nx_float;
      o_linear_address_out <= next_cyc_addr;
      o_linear_oe_n        <= nx_float;
      o_bus_status_n       <= nx_status_n;
      o_rd_n               <= nx_rd_n;
      o_wr_n               <= nx_wr_n;
      o_whb_n              <= nx_whb_n;
      o_wlb_n              <= nx_wlb_n;
      o_strobe_oe_n        <= nx_float;
      o_data_enable_n      <= nx_den_n;
      o_den_oe_n           <= nx_float;
      o_data_direction     <= nx_dir;
      o_dir_oe_n           <= nx_float;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst || !i_ce);

  AST_ALE_ADDR: assert property ($fell(o_ale) && !$past(o_mad_lo_oe_n) |->
    $past(o_muxed_addr_data[DATA_W-1:1]) == cyc_addr[DATA_W-1:1])
    else $error("Address not on muxed bus at latch fall.");
  AST_ASYNC_RDY: assert property ((state == lbi_pkg::ST_T3) && async_s |=>
    state == lbi_pkg::ST_T4) else $error("Async ready did not end the cycle.");
  AST_WAIT: assert property ((state == lbi_pkg::ST_T3 || state == lbi_pkg::ST_TW)
    && !rdy |=> state == lbi_pkg::ST_TW ##0 o_rd_n == $past(o_rd_n))
    else $error("Wait state missing while not ready.");
  AST_REFRESH_ENC: assert property ((state == lbi_pkg::ST_T1) && cyc_refresh |->
    o_bhe_n && o_muxed_addr_data[0]) else $error("Refresh encoding wrong.");
  AST_BHE_FLOAT: assert property (o_hlda |-> o_bhe_oe_n && o_dir_oe_n && o_den_oe_n)
    else $error("Outputs driven during hold.");
  AST_HOLD_ORDER: assert property ($rose(o_hlda) |-> !o_cs_force_high && o_strobe_oe_n
    && o_mad_hi_oe_n ##1 (o_cs_force_high || !o_hlda))
    else $error("Chip selects not forced high after float.");
  AST_HOLD_RELEASE: assert property ((state == lbi_pkg::ST_HOLD) && !hold_s |=>
    !o_hlda) else $error("Acknowledge kept after hold released.");
  AST_MIDCYCLE: assert property ((state == lbi_pkg::ST_T2) && hold_s |->
    ##1 !o_hlda ##1 !o_hlda) else $error("Hold granted inside a bus cycle.");
  AST_HI_FLOAT: assert property (in_data_phase(state) && o_whb_n |->
    o_mad_hi_oe_n) else $error("Upper byte driven without high write strobe.");
  AST_STRAP_LOW: assert property ((state == lbi_pkg::ST_T1) && strap_low |->
    !o_mad_lo_oe_n && !o_mad_hi_oe_n) else $error("Address not driven with strap low.");
  AST_SUPPRESS: assert property ((state == lbi_pkg::ST_T1) && cyc_suppress |->
    o_mad_lo_oe_n && !o_linear_oe_n) else $error("Suppressed address on muxed bus.");
  AST_DEN_DIR: assert property ($changed(o_data_direction) |-> o_data_enable_n)
    else $error("Data enable active at direction change.");

endmodule

/* File: hdl/lbi_pkg.sv */
// Package for the local bus control block: states, status codes and timing figures.
// Assumes a single 20 MHz core clock and no register bus.
package lbi_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_TW,
    ST_T4,
    ST_HOLD_ENTER,
    ST_HOLD
  } lbi_state_t;

  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // Synchroniser depth for the hold and asynchronous ready inputs.
  localparam int SYNC_STAGES = 2;

  // Strap sampling point, in core clocks after the reset release.
  localparam int STRAP_DELAY_CLKS = 1;

  localparam int CLK_PERIOD_NS = 50;

  // Bus status codes shown on bus_status_n.
  localparam logic [2:0] STAT_INTA    = 3'h0;
  localparam logic [2:0] STAT_IO_RD   = 3'h1;
  localparam logic [2:0] STAT_IO_WR   = 3'h2;
  localparam logic [2:0] STAT_MEM_RD  = 3'h5;
  localparam logic [2:0] STAT_MEM_WR  = 3'h6;
  localparam logic [2:0] STAT_PASSIVE = 3'h7;

  // Region codes for a requested cycle.
  localparam logic [1:0] REGION_OTHER = 2'h0;
  localparam logic [1:0] REGION_LOWER = 2'h1;
  localparam logic [1:0] REGION_UPPER = 2'h2;

endpackage

/* File: hdl/lbi_sync.sv */
// Multi-bit two-stage level synchroniser with clock enable.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ps
module lbi_sync #(
  parameter int WIDTH  = 2,
  parameter int STAGES = lbi_pkg::SYNC_STAGES
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage [STAGES];
  logic [WIDTH-1:0] next_stage [STAGES];

  // The first stage feeds only the next stage, never any logic.
  always_comb begin
    next_stage[0] = i_async;
    for (int i = 1; i < STAGES; i++) begin
      next_stage[i] = stage[i-1];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= '0;
      end
    end else if (i_ce) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= next_stage[i];
      end
    end
  end

  assign o_sync = stage[STAGES-1];

endmodule

/* File: hdl/lbi_strap.sv */
// Capture of the address-drive strap shortly after reset release.
// Assumes the strap pin is pulled high when left floating.
`timescale 1ns/1ps
module lbi_strap (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  input  wire logic i_ce,
  input  wire logic i_strap,
  output logic      o_strap_low
);

  logic [1:0] cnt;
  logic       done;
  logic [1:0] next_cnt;
  logic       next_done;
  logic       next_strap_low;

  // Sampled one clock after the first clock seen with reset released.
  always_comb begin
    next_cnt       = cnt;
    next_done      = done;
    next_strap_low = o_strap_low;
    if (!done) begin
      if (cnt == 2'(lbi_pkg::STRAP_DELAY_CLKS)) begin
        next_strap_low = !i_strap;
        next_done      = 1'b1;
      end else begin
        next_cnt = cnt + 2'h1;
      end
    end
  end

  // Default before sampling is the strap-high reading.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      cnt         <= 2'h0;
      done        <= 1'b0;
      o_strap_low <= 1'b0;
    end else if (i_ce) begin
      cnt         <= next_cnt;
      done        <= next_done;
      o_strap_low <= next_strap_low;
    end
  end

endmodule

/* File: tb/lbi_mem_model.sv */
// Partner model: memory and ready source on the far side of the local bus.
// Assumes registered strobes from the bus controller and a single clock.
`timescale 1ns/1ps
module lbi_mem_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_ale,
  input  wire logic [15:0] i_mad,
  input  wire logic        i_rd_n,
  input  wire logic [2:0]  i_stat,
  input  wire logic [3:0]  i_waits,
  input  wire logic        i_use_sync,
  output logic      [15:0] o_mad,
  output logic             o_async_ready,
  output logic             o_sync_ready
);
  logic [15:0] addr;
  logic [3:0]  cnt;
  logic        rdy;
  initial begin
    addr = 16'h0000;
    cnt = 4'h0;
    o_mad = 16'h0000;
  end
  // A released bus toggles, so a stale value can never pass for read data.
  always @(posedge i_core_clk) begin
    if (i_ale) addr <= i_mad;
    cnt <= (i_stat == lbi_pkg::STAT_PASSIVE) ? 4'h0 : cnt + 4'h1;
    o_mad <= !i_rd_n ? {addr[7:0], ~addr[15:8]} : ~o_mad;
  end
  // Ready follows the status, since a refresh cycle shows no read or write strobe.
  assign rdy = (i_stat != lbi_pkg::STAT_PASSIVE) && (cnt >= i_waits);
  assign o_async_ready = !i_use_sync && rdy;
  assign o_sync_ready = i_use_sync && rdy;
endmodule

/* File: tb/tb_local_bus_interface_control.sv */
// Testbench for the local bus controller: bus cycles, strap, hold handover.
// Assumes the partner model answers reads; the bench plays the hold master.
`timescale 1ns/1ps
module tb_local_bus_interface_control;
  logic        clk, nrst, valid, wr, word, rfsh, io, hold, strap, use_sync, ardy, srdy, dis;
  logic        ready, rvalid, hlda, csh, ale, bhe, bhe_oe, hi_oe, lo_oe, lin_oe, st_oe;
  logic        den_oe, dir, dir_oe, rd_n, wr_n, whb, wlb, den, inta, lk;
  logic [1:0]  region;
  logic [3:0]  waits;
  logic [19:0] addr, lin;
  logic [15:0] wdata, rdata, mad_o, mad_i, mem_o;
  logic [2:0]  stat;
  int          err_total, cmp_count, cyc;
  assign mad_i = {hi_oe ? mem_o[15:8] : mad_o[15:8], lo_oe ? mem_o[7:0] : mad_o[7:0]};
  lbi_bus_ctrl i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_ce(1'b1), .i_req_valid(valid),
    .i_req_write(wr), .i_req_word(word), .i_req_io(io), .i_req_inta(inta),
    .i_req_refresh(rfsh), .i_req_lock(lk), .i_req_region(region), .i_req_addr(addr),
    .i_req_wdata(wdata), .o_req_ready(ready), .o_rd_data(rdata), .o_rd_valid(rvalid),
    .i_lower_addr_disable_bit(dis), .i_upper_addr_disable_bit(dis), .i_async_ready(ardy),
    .i_sync_ready(srdy), .i_hold(hold), .o_hlda(hlda), .o_cs_force_high(csh), .o_ale(ale),
    .i_bhe_aden_n(bhe_oe ? strap : bhe), .o_bhe_n(bhe), .o_bhe_oe_n(bhe_oe),
    .i_muxed_addr_data(mad_i), .o_muxed_addr_data(mad_o), .o_mad_hi_oe_n(hi_oe),
    .o_mad_lo_oe_n(lo_oe), .o_linear_address_out(lin), .o_linear_oe_n(lin_oe),
    .o_bus_status_n(stat), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_whb_n(whb), .o_wlb_n(wlb),
    .o_strobe_oe_n(st_oe), .o_data_enable_n(den), .o_den_oe_n(den_oe),
    .o_data_direction(dir), .o_dir_oe_n(dir_oe));
  lbi_mem_model i_mem (.i_core_clk(clk), .i_ale(ale), .i_mad(mad_o), .i_rd_n(rd_n),
    .i_stat(stat), .i_waits(waits), .i_use_sync(use_sync), .o_mad(mem_o),
    .o_async_ready(ardy), .o_sync_ready(srdy));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [15:0] exp_rd(input logic [19:0] a);
    return {a[7:0], ~a[15:8]};
  endfunction
  function automatic logic [2:0] exp_stat(input logic we, ie, ae);
    if (ae) return lbi_pkg::STAT_INTA;
    if (ie) return we ? lbi_pkg::STAT_IO_WR : lbi_pkg::STAT_IO_RD;
    return we ? lbi_pkg::STAT_MEM_WR : lbi_pkg::STAT_MEM_RD;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic req(input logic w, wd, r, hm, input logic [1:0] rg, input logic [19:0] a);
    int n;
    logic sup;
    logic hw, lw;
    n = 0;
    sup = strap && dis && rg != 2'h0;
    hw = w && (wd || a[0]);
    lw = w && (wd || !a[0]);
    valid = 1'b1; wr = w; word = wd; rfsh = r; region = rg; addr = a; io = 1'($urandom);
    inta = !w && !r && ($urandom_range(3) == 0);
    wdata = 16'($urandom); waits = 4'($urandom_range(3)); use_sync = 1'($urandom);
    @(negedge clk);
    while (ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    #1 valid = 1'b0;
    @(negedge clk);
    chk("ale", 20'h1, ale);
    chk("bhe", r ? 20'h1 : 20'(!(wd | a[0])), bhe);
    chk("dir", 20'(w & !r), dir);
    chk("stat", 20'(exp_stat(w, io, inta)), 20'(stat));
    chk("mad_oe", 20'(sup), lo_oe);
    if (sup) chk("lin", a, lin);
    else chk("addr", 20'(a[15:0]), mad_o);
    @(posedge clk);
    #1 hold = hm;
    @(negedge clk);
    chk("strobes", 20'({r, w | r, !w, !hw, !lw, !hw, !lw}),
        20'({den, rd_n, wr_n, whb, wlb, hi_oe, lo_oe}));
    if (w) chk("wdata", 20'(wdata), 20'(mad_o));
    n = 0;
    if (!w && !r) begin
      while (rvalid !== 1'b1 && n < 20) begin
        @(negedge clk);
        n++;
      end
      chk("rdata", 20'(exp_rd(a)), rdata);
      chk("hlda_mid", 20'h0, hlda);
    end
    @(posedge clk);
    #1;
    if (hm && !w && !r) chk("hold_lat", 20'(!lk), 20'(hlda));
  endtask
  task automatic do_hold(input logic reclaim);
    int n;
    n = 0;
    hold = 1'b1;
    @(negedge clk);
    while (hlda !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("hlda", 20'h1, hlda);
    chk("float", 20'h7F, {bhe_oe, hi_oe, lo_oe, lin_oe, st_oe, den_oe, dir_oe});
    @(negedge clk);
    chk("cs_high", 20'h1, csh);
    @(posedge clk);
    #1;
    if (reclaim) begin
      req(1'b0, 1'b1, 1'b1, 1'b1, 2'h0, 20'h00001);
      chk("reclaim", 20'h0, hlda);
    end
    hold = 1'b0;
    n = 0;
    while (hlda !== 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("hlda_off", 20'h0, hlda);
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic s);
    nrst = 1'b0;
    strap = s;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic w, wd;
    {nrst, valid, wr, word, rfsh, io, hold, use_sync, dis, inta, lk} = '0;
    strap = 1'b1; region = 2'h0; addr = '0; wdata = '0; waits = 4'h0;
    err_total = 0; cmp_count = 0; cyc = 0;
    void'($urandom(58));
    @(posedge clk);
    #1;
    do_reset(1'b1);
    req(1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 20'h12344);
    req(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 20'h00101);
    req(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 20'h00100);
    req(1'b0, 1'b1, 1'b1, 1'b0, 2'h0, 20'h00001);
    dis = 1'b1;
    req(1'b1, 1'b1, 1'b0, 1'b0, 2'h1, 20'h02468);
    req(1'b1, 1'b1, 1'b0, 1'b0, 2'h2, 20'hF1234);
    repeat (30) begin
      w = 1'($urandom);
      wd = 1'($urandom);
      dis = 1'($urandom);
      addr = 20'($urandom);
      req(w, wd, 1'b0, 1'b0, w ? 2'($urandom_range(2)) : 2'h0, wd ? addr & 20'hFFFFE : addr);
    end
    do_hold(1'b0);
    do_hold(1'b1);
    lk = 1'b1;
    req(1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 20'h0ABCE);
    lk = 1'b0;
    do_hold(1'b0);
    req(1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 20'h0ABCE);
    do_hold(1'b0);
    do_reset(1'b0);
    dis = 1'b1;
    req(1'b1, 1'b1, 1'b0, 1'b0, 2'h1, 20'h03579);
    end_sim();
  end
endmodule
